// [src/sarrd_pkg.sv]
// ****************************************
// Shared constants and types
// ****************************************
`default_nettype none
package sarrd_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int RES_W     = 16;
	localparam int CHAIN_LEN = 16;
	localparam int CNT_W     = 5;
	localparam int CCNT_W    = 8;
	localparam int IDX_W     = 4;

	// ****************************************
	// Conversion timing
	// ****************************************
	localparam int CLK_MHZ       = 125;
	localparam int T_CONV_MIN_NS = 500;
	localparam int T_CONV_MAX_NS = 1600;
	localparam int NS_PER_US_K   = 1000;
	localparam int CONV_MIN_CYC  =
		(T_CONV_MIN_NS * CLK_MHZ + NS_PER_US_K - 1) / NS_PER_US_K;
	localparam int CONV_MAX_CYC  = (T_CONV_MAX_NS * CLK_MHZ) / NS_PER_US_K;
	// Shortest legal time: host waits less, throughput is highest
	localparam int CONV_CYC      = CONV_MIN_CYC;

	localparam logic [CCNT_W-1:0] CONV_LAST  = CCNT_W'(CONV_CYC - 1);
	localparam logic [CCNT_W-1:0] CCNT_ZERO  = 8'h00;
	localparam logic [CCNT_W-1:0] CCNT_ONE   = 8'h01;
	localparam logic [CNT_W-1:0]  CNT_ZERO   = 5'h00;
	localparam logic [CNT_W-1:0]  CNT_ONE    = 5'h01;
	localparam logic [CNT_W-1:0]  CNT_MAX    = 5'h1f;
	localparam logic [CNT_W-1:0]  CNT_RES    = CNT_W'(RES_W);
	localparam logic [IDX_W-1:0]  MSB_IDX    = 4'hf;
	localparam logic [RES_W-1:0]  WORD_ZERO  = 16'h0000;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CONV,
		ST_READY
	} sarrd_state_e;

	typedef logic [RES_W-1:0] sarrd_word_t;

	// Interface mode and readout flags of one conversion
	typedef struct packed {
		logic chain;
		logic busy_mark;
		logic valid;
	} sarrd_frame_s;

	localparam sarrd_frame_s FRAME_RST = '{chain: 1'b0, busy_mark: 1'b0,
		valid: 1'b0};

endpackage : sarrd_pkg
`default_nettype wire

// [src/sarrd_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Two-stage pin synchroniser
// ****************************************
module sarrd_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// Asynchronous levels in, synchronised levels out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule : sarrd_sync
`default_nettype wire

// [src/sarrd_top.sv]
// What this block does
// - Each convert strobe rising edge starts a conversion and latches mode.
// - Input code is held at the strobe rising edge as sample.
// - Chain input low at strobe rise selects daisy-chain mode.
// - Chain input high at strobe rise selects select mode.
// - Select mode: strobe low turns the output driver on during conversion and until the last bit.
// - Select mode: strobe low or chain input low enables output.
// - Select mode: enable low at completion turns on busy indication.
// - Result leaves on serial output, changing on serial clock.
// - Selected device shifts one result bit per serial clock.
// - Chain mode: upstream result bits enter on chain input.
// - Chain mode: chain input reappears on output sixteen clocks later.
// - Select mode: enable going low presents bit fifteen first.
// - Select mode: output released when deselected or after last bit.
// - Data ready 0.5 to 1.6 us after strobe rise; host waits.
`timescale 1ns/1ps
`default_nettype none
module sarrd_top (
	// System clock and reset
	input  wire logic                      CLK,
	input  wire logic                      SRST,
	// Converter core
	input  wire sarrd_pkg::sarrd_word_t    ANALOG_CODE,
	// Serial link
	input  wire logic                      SER_CLK,
	input  wire logic                      CONVERT_STROBE,
	input  wire logic                      SERIAL_CHAIN_IN,
	output logic                           SERIAL_RESULT_OUT,
	output logic                           SERIAL_RESULT_OUT_OE_N
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [1:0] pin_raw;
	logic [1:0] pin_s;
	logic       cnv_s;
	logic       sdi_s;

	assign pin_raw = {CONVERT_STROBE, SERIAL_CHAIN_IN};
	assign cnv_s   = pin_s[1];
	assign sdi_s   = pin_s[0];

	sarrd_sync #(
		.W (2)
	) u_sync (
		.clk  (CLK),
		.srst (SRST),
		.d    (pin_raw),
		.q    (pin_s)
	);

	// ****************************************
	// Conversion control
	// ****************************************
	sarrd_pkg::sarrd_state_e                state_q;
	sarrd_pkg::sarrd_state_e                state_d;
	logic                                   cnv_prev_q;
	logic [sarrd_pkg::CCNT_W-1:0]           ccnt_q;
	logic [sarrd_pkg::CCNT_W-1:0]           ccnt_d;
	sarrd_pkg::sarrd_word_t                 sample_q;
	sarrd_pkg::sarrd_word_t                 result_q;
	sarrd_pkg::sarrd_frame_s                frame_q;
	sarrd_pkg::sarrd_frame_s                frame_d;
	logic                                   link_hold_q;
	logic                                   cnv_rise;
	logic                                   conv_done;
	logic                                   cs_low;

	assign cnv_rise  = cnv_s & ~cnv_prev_q;
	assign conv_done = (state_q == sarrd_pkg::ST_CONV) &&
		(ccnt_q == sarrd_pkg::CONV_LAST);
	assign cs_low    = ~cnv_s | ~sdi_s;
	assign ccnt_d    = cnv_rise ? sarrd_pkg::CCNT_ZERO :
		ccnt_q + sarrd_pkg::CCNT_ONE;

	// A new edge restarts even a running conversion
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			sarrd_pkg::ST_IDLE,
			sarrd_pkg::ST_READY: begin
				if (cnv_rise)
					state_d = sarrd_pkg::ST_CONV;
			end
			sarrd_pkg::ST_CONV: begin
				if (cnv_rise)
					state_d = sarrd_pkg::ST_CONV;
				else if (conv_done)
					state_d = sarrd_pkg::ST_READY;
			end
		endcase
	end

	always_comb begin
		frame_d = frame_q;
		if (cnv_rise) begin
			frame_d.chain     = ~sdi_s;
			frame_d.busy_mark = 1'b0;
			frame_d.valid     = 1'b0;
		end else if (conv_done) begin
			frame_d.valid     = 1'b1;
			// Busy marker when selected at completion
			frame_d.busy_mark = ~frame_q.chain & cs_low;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			state_q    <= sarrd_pkg::ST_IDLE;
			cnv_prev_q <= 1'b0;
			ccnt_q     <= sarrd_pkg::CCNT_ZERO;
			frame_q    <= sarrd_pkg::FRAME_RST;
		end else begin
			state_q    <= state_d;
			cnv_prev_q <= cnv_s;
			ccnt_q     <= ccnt_d;
			frame_q    <= frame_d;
		end
	end

	// Hold the input difference at the edge
	always_ff @(posedge CLK) begin
		if (SRST)
			sample_q <= sarrd_pkg::WORD_ZERO;
		else if (cnv_rise)
			sample_q <= ANALOG_CODE;
	end

	// Word published once conversion time has run
	always_ff @(posedge CLK) begin
		if (SRST)
			result_q <= sarrd_pkg::WORD_ZERO;
		else if (conv_done && !cnv_rise)
			result_q <= sample_q;
	end

	// Link logic held clear outside the readout phase
	always_ff @(posedge CLK) begin
		if (SRST)
			link_hold_q <= 1'b1;
		else
			// Release lags READY a cycle so word and flags settle first
			link_hold_q <= (state_d != sarrd_pkg::ST_READY) ||
				(state_q != sarrd_pkg::ST_READY);
	end

	// ****************************************
	// Serial clock domain
	// ****************************************
	// result_q and frame_q are static while link_hold_q is low, so
	// the link side may read them without a synchroniser.
	logic [sarrd_pkg::CNT_W-1:0]     cnt_q;
	logic [sarrd_pkg::CNT_W-1:0]     cnt_inc;
	logic [sarrd_pkg::CNT_W-1:0]     pos_next;
	logic [sarrd_pkg::CHAIN_LEN-1:0] chain_q;
	logic [sarrd_pkg::CHAIN_LEN-1:0] chain_d;
	logic [sarrd_pkg::IDX_W-1:0]     bit_sel;
	logic                            lbit_q;
	logic                            lbit_d;
	logic [sarrd_pkg::CNT_W-1:0]     mark_w;

	assign mark_w   = {{(sarrd_pkg::CNT_W-1){1'b0}}, frame_q.busy_mark};
	assign cnt_inc  = (cnt_q == sarrd_pkg::CNT_MAX) ? cnt_q :
		cnt_q + sarrd_pkg::CNT_ONE;
	assign pos_next = cnt_inc - mark_w;
	// Upstream bits enter the chain path
	assign chain_d  = {chain_q[sarrd_pkg::CHAIN_LEN-2:0], SERIAL_CHAIN_IN};
	assign bit_sel  = sarrd_pkg::MSB_IDX - pos_next[sarrd_pkg::IDX_W-1:0];
	// Own word first, then input from sixteen clocks back
	assign lbit_d   = (pos_next < sarrd_pkg::CNT_RES) ? result_q[bit_sel] :
		chain_d[sarrd_pkg::CHAIN_LEN-1];

	// One bit per falling serial clock edge
	always_ff @(negedge SER_CLK or posedge link_hold_q) begin
		if (link_hold_q) begin
			cnt_q   <= sarrd_pkg::CNT_ZERO;
			chain_q <= '0;
			lbit_q  <= 1'b0;
		end else begin
			cnt_q   <= cnt_inc;
			chain_q <= chain_d;
			lbit_q  <= lbit_d;
		end
	end

	// ****************************************
	// Output pin
	// ****************************************
	logic first_bit;
	logic data_left;
	logic sel_drive;
	logic out_drive;

	// Busy marker, else bit fifteen, shows before any clock edge
	assign first_bit = frame_q.busy_mark | result_q[sarrd_pkg::RES_W-1];
	// Released after the last data bit
	assign data_left = cnt_q < (sarrd_pkg::CNT_RES + mark_w);
	// Selected while converting or while bits remain
	assign sel_drive = cs_low && ((state_q == sarrd_pkg::ST_CONV) ||
		((state_q == sarrd_pkg::ST_READY) && data_left));
	assign out_drive = frame_q.chain ? (state_q != sarrd_pkg::ST_IDLE) :
		sel_drive;

	// Busy low during conversion, then the shifted word
	assign SERIAL_RESULT_OUT      = (state_q != sarrd_pkg::ST_READY) ? 1'b0 :
		((cnt_q == sarrd_pkg::CNT_ZERO) ? first_bit : lbit_q);
	assign SERIAL_RESULT_OUT_OE_N = ~out_drive;

	// ****************************************
	// Checks
	// ****************************************
	logic [sarrd_pkg::CCNT_W-1:0] age_q;

	always_ff @(posedge CLK) begin
		if (SRST || cnv_rise)
			age_q <= sarrd_pkg::CCNT_ZERO;
		else if (age_q != '1)
			age_q <= age_q + sarrd_pkg::CCNT_ONE;
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	a_conv_start: assert property (
		cnv_rise |=> state_q == sarrd_pkg::ST_CONV &&
		ccnt_q == sarrd_pkg::CCNT_ZERO)
		else $error("conversion did not start on strobe edge");

	a_sample_held: assert property (
		cnv_rise |=> sample_q == $past(ANALOG_CODE))
		else $error("sample not taken at strobe edge");

	a_chain_mode: assert property (
		cnv_rise && !sdi_s |=> frame_q.chain ##1 frame_q.chain)
		else $error("chain mode not latched");

	a_select_mode: assert property (
		cnv_rise && sdi_s |=> !frame_q.chain)
		else $error("select mode not latched");

	// Driver on while strobe low in conversion
	a_sel_drive: assert property (
		state_q == sarrd_pkg::ST_CONV && !frame_q.chain && !cnv_s
		|-> !SERIAL_RESULT_OUT_OE_N && !SERIAL_RESULT_OUT)
		else $error("select mode output not driven low while busy");

	a_busy_mark: assert property (
		conv_done && !cnv_rise && !frame_q.chain && cs_low
		|=> frame_q.busy_mark && frame_q.valid)
		else $error("busy marker not set at completion");

	a_deselect_off: assert property (
		!frame_q.chain && cnv_s && sdi_s |-> SERIAL_RESULT_OUT_OE_N)
		else $error("output driven while deselected");

	a_conv_window: assert property (
		$rose(state_q == sarrd_pkg::ST_READY)
		|-> age_q >= 8'(sarrd_pkg::CONV_MIN_CYC) &&
		age_q <= 8'(sarrd_pkg::CONV_MAX_CYC))
		else $error("conversion time out of window");

	a_result_load: assert property (
		$rose(state_q == sarrd_pkg::ST_READY) |-> result_q == sample_q &&
		link_hold_q ##1 !link_hold_q)
		else $error("result or link release wrong at completion");

	c_chain_conv: cover property (
		cnv_rise && !sdi_s ##[1:300] state_q == sarrd_pkg::ST_READY);
	c_busy_mark: cover property (
		conv_done && cs_low && !frame_q.chain);
	c_restart: cover property (
		state_q == sarrd_pkg::ST_CONV && cnv_rise);
	c_cnv_select: cover property (
		cnv_rise && sdi_s ##[1:300] state_q == sarrd_pkg::ST_READY && !cnv_s);

	a_busy_level: assert property (
		state_q == sarrd_pkg::ST_CONV |-> !SERIAL_RESULT_OUT)
		else $error("output not low during conversion");

	a_link_held: assert property (
		state_q == sarrd_pkg::ST_CONV |->
		link_hold_q && cnt_q == sarrd_pkg::CNT_ZERO)
		else $error("link not held clear during conversion");

	a_chain_drive: assert property (
		frame_q.chain && state_q != sarrd_pkg::ST_IDLE
		|-> !SERIAL_RESULT_OUT_OE_N)
		else $error("chain mode output not driven");

	a_first_bit: assert property (
		state_q == sarrd_pkg::ST_READY && !frame_q.busy_mark &&
		cnt_q == sarrd_pkg::CNT_ZERO
		|-> SERIAL_RESULT_OUT == result_q[sarrd_pkg::RES_W-1])
		else $error("first bit is not bit fifteen");

endmodule : sarrd_top
`default_nettype wire

// [tb/sarrd_host.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host serial controller model
// ****************************************
module sarrd_host (
	// Link pins driven by the host
	output logic     sck,
	output logic     convert_strobe,
	output logic     serial_chain_in,
	// Result pin read by the host
	input wire logic serial_result_out
);
	initial begin
		sck = 1'b0;
		convert_strobe = 1'b0;
		serial_chain_in = 1'b1;
	end

	// Mode level first
	// Level set one half clock ahead of the strobe edge
	task automatic start(input logic chain, input logic hold);
		convert_strobe = 1'b0;
		serial_chain_in = ~chain;
		#24 convert_strobe = 1'b1;
		#24 serial_chain_in = hold;
	endtask : start

	// Bit per clock
	// Clock stands low between frames; caller waits for data first
	task automatic shift(input int n, input logic chain,
		input logic [15:0] up, output logic [31:0] got);
		got = 32'h0000_0000;
		for (int i = 0; i < n; i++) begin
			#12 got = {got[30:0], serial_result_out};
			// Upstream bit set well before the falling edge
			if (chain)
				serial_chain_in = (i < 16) ? up[15-i] : ~serial_chain_in;
			#12 sck = 1'b1;
			#24 sck = 1'b0;
		end
	endtask : shift
endmodule : sarrd_host
`default_nettype wire

// [tb/sar_adc_serial_readout_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module sar_adc_serial_readout_tb;
	logic                   clk;
	logic                   srst;
	sarrd_pkg::sarrd_word_t code;
	wire logic              sck;
	wire logic              convert_strobe;
	wire logic              serial_chain_in;
	logic                   serial_result_out;
	logic                   oe_n;
	logic [31:0]            got;
	int                     fail_count;
	int                     samples_checked;

	sarrd_top uut (
		.CLK                    (clk),
		.SRST                   (srst),
		.ANALOG_CODE            (code),
		.SER_CLK                (sck),
		.CONVERT_STROBE         (convert_strobe),
		.SERIAL_CHAIN_IN        (serial_chain_in),
		.SERIAL_RESULT_OUT      (serial_result_out),
		.SERIAL_RESULT_OUT_OE_N (oe_n)
	);

	sarrd_host host (
		.sck (sck),
		.convert_strobe (convert_strobe),
		.serial_chain_in (serial_chain_in),
		.serial_result_out (serial_result_out)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s exp %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic set_code(input logic [15:0] v);
		@(posedge clk);
		#1 code = v;
	endtask : set_code

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_select();
		set_code(16'hA5C3);
		host.start(1'b0, 1'b1);
		// Clocks during conversion must not shift anything
		host.shift(3, 1'b0, 16'h0000, got);
		set_code(16'h0F0F);
		check("oe idle", 32'h0000_0001, 32'(oe_n));
		#1000 host.convert_strobe = 1'b0;
		#48 check("oe cnv low", 32'h0000_0000, 32'(oe_n));
		host.shift(16, 1'b0, 16'h0000, got);
		check("word", 32'h0000_A5C3, got);
		#48 check("oe last", 32'h0000_0001, 32'(oe_n));
		$display("test_select done");
	endtask : test_select

	task automatic test_busy();
		set_code(16'h3C5A);
		host.start(1'b0, 1'b0);
		#400 check("busy low", 32'h0000_0000, 32'(serial_result_out));
		#1176 check("ready", 32'h0000_0001, 32'(serial_result_out));
		host.serial_chain_in = 1'b1;
		#48 check("oe desel", 32'h0000_0001, 32'(oe_n));
		host.serial_chain_in = 1'b0;
		#48 check("oe sdi low", 32'h0000_0000, 32'(oe_n));
		host.shift(17, 1'b0, 16'h0000, got);
		check("marked", 32'h0001_3C5A, got);
		#48 check("oe end", 32'h0000_0001, 32'(oe_n));
		$display("test_busy done");
	endtask : test_busy

	task automatic test_chain();
		set_code(16'h1234);
		host.start(1'b1, 1'b0);
		#1000 check("oe chain", 32'h0000_0000, 32'(oe_n));
		host.shift(32, 1'b1, 16'hBEEF, got);
		check("chain", 32'h1234_BEEF, got);
		$display("test_chain done");
	endtask : test_chain

	task automatic test_cnv_low();
		set_code(16'h5A3C);
		host.start(1'b0, 1'b1);
		// Strobe alone selects; still low at completion marks busy
		host.convert_strobe = 1'b0;
		#400 check("oe busy", 32'h0000_0000, 32'(oe_n));
		check("busy cnv", 32'h0000_0000, 32'(serial_result_out));
		#1176 check("mark cnv", 32'h0000_0001, 32'(serial_result_out));
		host.shift(17, 1'b0, 16'h0000, got);
		check("cnv word", 32'h0001_5A3C, got);
		#48 check("oe cnv end", 32'h0000_0001, 32'(oe_n));
		$display("test_cnv_low done");
	endtask : test_cnv_low

	initial begin
		srst = 1'b1;
		code = 16'h0000;
		fail_count = 0;
		samples_checked = 0;
		repeat (8) @(posedge clk);
		#1 srst = 1'b0;
		test_select();
		test_busy();
		test_chain();
		test_cnv_low();
		tally_and_finish();
	end

	// Tests need about ten microseconds
	initial begin
		#50000;
		fail_count++;
		tally_and_finish();
	end
endmodule : sar_adc_serial_readout_tb
`default_nettype wire
